// ==== hw/scirq_params.svh ====
// constants of the smartcard fault, event and card reset block
// assumes a single 20 MHz clock and an AXI4-Lite register port
// Contract
// - async mode: sequencer alone drives card reset
// - sync mode: slot 0 reset follows bit3 one cycle later, other slots sequencer
// - reset pin current limit never deactivates card
// - open-drain active-low request while anything pending
// - card insert/remove sets event7 and presence flag
// - event register read clears bits, releases request
// - presence flag cleared only by its status read
// - overcurrent sets slot bit4 and slot event
// - sticky slot flags cleared only by slot read
// - main supply low sets event2 and state1
// - supervisor and thermal state bits are live
// - over-temperature sets event3 and state2
// - early answer sets bit6 and slot event
// - late answer sets bit5 and slot event
// - sync activation done sets event1
// - supply ramp timeout sets bit0 and slot event
// - input pin change sets event0
// - after power-on, request with no event bits
// - functions unavailable until power-on sequence ends, one cycle before request raised
// - main undervoltage deactivates every card interface
// - io undervoltage deactivates all, power-off, no fault
`ifndef SCIRQ_PARAMS_SVH
`define SCIRQ_PARAMS_SVH
`define SCIRQ_IDX_UC_STATUS 8'h00
`define SCIRQ_IDX_SYNC_SET 8'h09
`define SCIRQ_IDX_S1_STATUS 8'h10
`define SCIRQ_IDX_S2_STATUS 8'h20
`define SCIRQ_IDX_S3_STATUS 8'h30
`define SCIRQ_IDX_EVENT 8'h41
`define SCIRQ_IDX_CTRL 8'h50
`define SCIRQ_BIT_RAMP 0
`define SCIRQ_BIT_SUPL 1
`define SCIRQ_BIT_PRES 2
`define SCIRQ_BIT_OTP 2
`define SCIRQ_BIT_SYNC_RST 3
`define SCIRQ_BIT_OVERCURRENT_FLAG 4
`define SCIRQ_BIT_MUTE 5
`define SCIRQ_BIT_EARLY 6
`define SCIRQ_EV_GPIO 0
`define SCIRQ_EV_SYNC 1
`define SCIRQ_EV_SUPL 2
`define SCIRQ_EV_OTP 3
`define SCIRQ_EV_UC 7
`define SCIRQ_RESET_BYTE 8'h00
`define SCIRQ_POR_DELAY_NS 1000
`define SCIRQ_CLK_NS 50
`define SCIRQ_POR_CYC ((`SCIRQ_POR_DELAY_NS + `SCIRQ_CLK_NS - 1) / `SCIRQ_CLK_NS)
`endif

// ==== hw/scirq_pkg.sv ====
// types of the smartcard fault and event block
// assumes the constants header is included alongside
package scirq_pkg;
    typedef logic [7:0] scirq_byte_t;
    typedef logic [3:0] scirq_slots_t;
    typedef enum logic [1:0] {
        SCIRQ_OFF,
        SCIRQ_RAMP,
        SCIRQ_READY
    } scirq_pwr_t;
endpackage

// ==== hw/scirq_top.sv ====
// fault/event flags, request pin and card reset control, behind AXI4-Lite
// assumes fault inputs are asynchronous pins; sequencer inputs share aclk
`timescale 1ns/10ps
`include "scirq_params.svh"
module scirq_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic user_card_present,
    input wire scirq_pkg::scirq_slots_t slot_overcurrent,
    input wire logic main_supply_low,
    input wire logic io_supply_low,
    input wire logic over_temp,
    input wire logic [7:0] gpio_in,
    input wire scirq_pkg::scirq_slots_t atr_early,
    input wire scirq_pkg::scirq_slots_t atr_late,
    input wire scirq_pkg::scirq_slots_t ramp_timeout,
    input wire logic sync_act_done,
    input wire scirq_pkg::scirq_slots_t seq_rst,
    input wire scirq_pkg::scirq_slots_t rst_limit,
    output scirq_pkg::scirq_slots_t card_rst,
    output scirq_pkg::scirq_slots_t deactivate_all,
    output logic power_off,
    output logic functions_ready,
    output logic irq_o,
    output logic irq_oe
);
    import scirq_pkg::*;

    // three-stage synchronisers for pin inputs: index 0..7 gpio, 8 presence,
    // 9 main low, 10 io low, 11 over-temp, 12..15 overcurrent
    logic [15:0] pin_raw;
    logic [15:0] s1_r, s2_r, s3_r, pin_r;
    assign pin_raw = {slot_overcurrent, over_temp, io_supply_low, main_supply_low,
                      user_card_present, gpio_in};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_r <= 16'h0000;
            s2_r <= 16'h0000;
            s3_r <= 16'h0000;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_filt
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pin_r[gi] <= 1'b0;
                end else if (s2_r[gi] == s3_r[gi]) begin
                    pin_r[gi] <= s3_r[gi];
                end
            end
        end
    endgenerate
    logic [15:0] pin_d_r;
    logic pin_prime_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_d_r <= 16'h0000;
            pin_prime_r <= 1'b0;
        end else begin
            pin_d_r <= pin_r;
            pin_prime_r <= 1'b1;
        end
    end
    logic [15:0] pin_rise, pin_chg;
    assign pin_chg = pin_prime_r ? (pin_r ^ pin_d_r) : 16'h0000;
    assign pin_rise = pin_chg & pin_r;

    // power-on sequencing
    scirq_pwr_t pwr_r;
    logic [7:0] por_cnt_r;
    logic por_req_r;
    logic io_low;
    assign io_low = pin_r[10];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_r <= SCIRQ_OFF;
            por_cnt_r <= 8'h00;
        end else if (io_low) begin
            pwr_r <= SCIRQ_OFF;
            por_cnt_r <= 8'h00;
        end else begin
            unique case (pwr_r)
                SCIRQ_OFF: begin
                    pwr_r <= SCIRQ_RAMP;
                end
                SCIRQ_RAMP: begin
                    por_cnt_r <= por_cnt_r + 8'h01;
                    if (por_cnt_r == 8'(`SCIRQ_POR_CYC - 1)) begin
                        pwr_r <= SCIRQ_READY;
                    end
                end
                SCIRQ_READY: begin
                    pwr_r <= SCIRQ_READY;
                end
            endcase
        end
    end
    logic ready;
    assign ready = (pwr_r == SCIRQ_READY);
    assign power_off = (pwr_r == SCIRQ_OFF);
    assign functions_ready = ready;

    // bus slave
    logic aw_held_r, w_held_r;
    logic [7:0] aw_addr_r, rd_addr;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_fire, rd_fire;
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'h0;
    assign s_axi_rresp = 2'h0;

    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] idx);
        is_reg = (a[7:2] == idx[5:0]) && (a[1:0] == 2'h0);
    endfunction
    // byte address is four times the printed index
    function automatic logic hits(input logic [7:0] a, input logic [7:0] idx);
        hits = ({a[7:2], 2'h0} == {idx[5:0], 2'h0}) && (a[1:0] == 2'h0) && (idx[7:6] == 2'h0);
    endfunction

    logic [7:0] sync_set_r;
    logic [3:0] sync_mode_r;
    logic wr_sync, wr_ctrl;
    assign wr_sync = wr_fire && hits(aw_addr_r, `SCIRQ_IDX_SYNC_SET) && w_strb_r[0];
    assign wr_ctrl = wr_fire && is_reg(aw_addr_r, 8'h14) && w_strb_r[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_set_r <= `SCIRQ_RESET_BYTE;
            sync_mode_r <= 4'h0;
        end else begin
            if (wr_sync) begin
                sync_set_r <= w_data_r[7:0];
            end
            if (wr_ctrl) begin
                sync_mode_r <= w_data_r[3:0];
            end
        end
    end

    // read strobes that clear flags
    logic rd_event, rd_uc;
    logic [3:0] rd_slot;
    // four times the event index wraps on the 8-bit address bus
    assign rd_event = rd_fire && rd_addr == {6'(`SCIRQ_IDX_EVENT), 2'h0};
    assign rd_uc = rd_fire && rd_addr == 8'h00;
    assign rd_slot[0] = rd_uc;
    assign rd_slot[1] = rd_fire && rd_addr == 8'h40;
    assign rd_slot[2] = rd_fire && rd_addr == 8'h80;
    assign rd_slot[3] = rd_fire && rd_addr == 8'hc0;

    // per-slot sticky flags: ramp, overcurrent, late, early
    logic [3:0] ramp_r, overcurrent_flag_r, mute_r, early_r;
    logic pres_r;
    logic [3:0] oc_rise;
    assign oc_rise = ready ? pin_rise[15:12] : 4'h0;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_slot
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    ramp_r[gi] <= 1'b0;
                    overcurrent_flag_r[gi] <= 1'b0;
                    mute_r[gi] <= 1'b0;
                    early_r[gi] <= 1'b0;
                end else begin
                    // set wins over the clearing read
                    ramp_r[gi] <= (ready && ramp_timeout[gi]) || (ramp_r[gi] && !rd_slot[gi]);
                    overcurrent_flag_r[gi] <= oc_rise[gi] || (overcurrent_flag_r[gi] && !rd_slot[gi]);
                    mute_r[gi] <= (ready && atr_late[gi]) || (mute_r[gi] && !rd_slot[gi]);
                    early_r[gi] <= (ready && atr_early[gi]) || (early_r[gi] && !rd_slot[gi]);
                end
            end
        end
    endgenerate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pres_r <= 1'b0;
        end else begin
            pres_r <= (ready && pin_chg[8]) || (pres_r && !rd_uc);
        end
    end

    // event register bits
    logic [3:0] slot_ev;
    logic [7:0] ev_r, ev_set;
    logic por_pend_r;
    assign slot_ev = oc_rise | ((atr_early | atr_late | ramp_timeout) & {4{ready}});
    always_comb begin
        ev_set = 8'h00;
        ev_set[`SCIRQ_EV_UC] = slot_ev[0] || (ready && pin_chg[8]);
        ev_set[6:4] = slot_ev[3:1];
        ev_set[`SCIRQ_EV_OTP] = ready && pin_rise[11];
        ev_set[`SCIRQ_EV_SUPL] = ready && pin_rise[9];
        ev_set[`SCIRQ_EV_SYNC] = ready && sync_act_done;
        ev_set[`SCIRQ_EV_GPIO] = ready && (pin_chg[7:0] != 8'h00);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_r <= 8'h00;
        end else begin
            ev_r <= ev_set | (rd_event ? 8'h00 : ev_r);
        end
    end
    logic ready_d_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_d_r <= 1'b0;
            por_pend_r <= 1'b0;
        end else begin
            ready_d_r <= ready;
            if (ready && !ready_d_r) begin
                por_pend_r <= 1'b1;
            end else if (rd_event) begin
                por_pend_r <= 1'b0;
            end
        end
    end

    // request pin: pull low while anything pending
    assign irq_o = 1'b0;
    assign irq_oe = (ev_r != 8'h00) || por_pend_r;

    // live state bits in the first secure-slot status register
    logic [7:0] s1_live;
    always_comb begin
        s1_live = 8'h00;
        s1_live[`SCIRQ_BIT_SUPL] = pin_r[9];
        s1_live[`SCIRQ_BIT_OTP] = pin_r[11];
    end
    function automatic logic [7:0] slot_byte(input int s);
        slot_byte = {1'b0, early_r[s], mute_r[s], overcurrent_flag_r[s], 3'h0, ramp_r[s]};
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            unique case (rd_addr)
                8'h00: s_axi_rdata <= {24'h0, slot_byte(0) | {5'h0, pres_r, 2'h0}};
                8'h24: s_axi_rdata <= {24'h0, sync_set_r};
                8'h40: s_axi_rdata <= {24'h0, slot_byte(1) | s1_live};
                8'h80: s_axi_rdata <= {24'h0, slot_byte(2)};
                8'hc0: s_axi_rdata <= {24'h0, slot_byte(3)};
                8'h04: s_axi_rdata <= {24'h0, ev_r};
                8'h50: s_axi_rdata <= {28'h0, sync_mode_r};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // card reset pins and deactivation
    logic main_low;
    assign main_low = pin_r[9];
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rst
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    card_rst[gi] <= 1'b0;
                end else if (gi == 0 && sync_mode_r[0] && sync_mode_r[1]) begin
                    card_rst[gi] <= sync_set_r[`SCIRQ_BIT_SYNC_RST];
                end else begin
                    card_rst[gi] <= seq_rst[gi];
                end
            end
        end
    endgenerate
    // current limit on the reset pins stays analog: rst_limit deactivates nothing
    assign deactivate_all = {4{main_low || io_low || !ready}};

    property p_ev_clear;
        @(posedge aclk) disable iff (!aresetn)
        rd_event && ev_set == 8'h00 |=> ev_r == 8'h00;
    endproperty
    a_ev_clear: assert property (p_ev_clear) else $error("event not cleared");
    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
        (ev_r != 8'h00) |-> irq_oe && !irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("request not low");
    property p_overcurrent_flag_sticky;
        @(posedge aclk) disable iff (!aresetn)
        overcurrent_flag_r[2] && !rd_slot[2] && rd_event |=> overcurrent_flag_r[2];
    endproperty
    a_overcurrent_flag_sticky: assert property (p_overcurrent_flag_sticky) else $error("overcurrent lost");
    property p_pres;
        @(posedge aclk) disable iff (!aresetn)
        pres_r && rd_event && !rd_uc |=> pres_r;
    endproperty
    a_pres: assert property (p_pres) else $error("presence lost");
    property p_oc;
        @(posedge aclk) disable iff (!aresetn)
        oc_rise[1] |=> overcurrent_flag_r[1] && ev_r[4];
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent not flagged");
    property p_live;
        @(posedge aclk) disable iff (!aresetn)
        rd_fire && rd_addr == 8'h40 |=> s_axi_rdata[`SCIRQ_BIT_SUPL] == $past(pin_r[9]);
    endproperty
    a_live: assert property (p_live) else $error("supply state stuck");
    property p_por;
        @(posedge aclk) disable iff (!aresetn)
        ready && !ready_d_r && !io_low |=> irq_oe;
    endproperty
    a_por: assert property (p_por) else $error("power-on request missing");
    property p_deact;
        @(posedge aclk) disable iff (!aresetn)
        io_low |=> power_off && deactivate_all == 4'hf;
    endproperty
    a_deact: assert property (p_deact) else $error("io low not handled");
    property p_sync_rst;
        @(posedge aclk) disable iff (!aresetn)
        sync_mode_r[1:0] == 2'h3 |=> card_rst[0] == $past(sync_set_r[3]);
    endproperty
    a_sync_rst: assert property (p_sync_rst) else $error("sync reset wrong");
    c_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire);
    c_evrd: cover property (@(posedge aclk) disable iff (!aresetn) rd_event && ev_r != 8'h00);
    c_por: cover property (@(posedge aclk) disable iff (!aresetn) ready && !ready_d_r);
    c_sync: cover property (@(posedge aclk) disable iff (!aresetn) sync_mode_r[1:0] == 2'h3);
endmodule

// ==== verif/scirq_host.sv ====
// host model: AXI4-Lite master that reads and writes registers and services the request line
// assumes the slave answers on aclk; handshakes are judged from values settled at the falling edge
`timescale 1ns/10ps
module scirq_host (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        // released address shows no stale value
        araddr <= ~a;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(negedge aclk);
            aw_done = aw_done | (awready === 1'b1);
            w_done = w_done | (wready === 1'b1);
            @(posedge aclk);
            if (aw_done) {awvalid, awaddr} <= {1'b0, ~a};
            if (w_done) {wvalid, wdata} <= {1'b0, ~d};
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    // event register first, then each slot whose event bit is up
    task automatic service(output logic [31:0] ev, output logic [31:0] st [4]);
        logic [3:0] flagged;
        rd(8'h04, ev);
        flagged = {ev[6:4], ev[7]};
        for (int s = 0; s < 4; s++) begin
            st[s] = 32'h0;
            if (flagged[s]) rd(8'(s * 64), st[s]);
        end
    endtask
endmodule

// ==== verif/smartcard_fault_irq_and_reset_ctrl_bench.sv ====
// self-checking bench of the fault, event and card reset block against an integer model
// assumes pin filters settle within 8 cycles and the host model owns the register port
`timescale 1ns/10ps
module smartcard_fault_irq_and_reset_ctrl_bench;
    import scirq_pkg::*;
    logic aclk = 1'b0;
    logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, user_card_present, main_supply_low;
    logic io_supply_low, over_temp, sync_act_done, power_off, functions_ready, irq_o, irq_oe;
    logic [7:0] awaddr, araddr, gpio_in;
    logic [31:0] wdata, rdata, ev, r;
    logic [31:0] st [4];
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    scirq_slots_t slot_overcurrent, atr_early, atr_late, ramp_timeout, seq_rst, rst_limit;
    scirq_slots_t card_rst, deactivate_all;
    int ev_m, live_m, sync_m, gq, e;
    int st_m [4];
    int kbit [4] = '{4, 6, 5, 0};
    int seed = 36253;
    int n_mismatch = 0;
    int comparisons = 0;

    always #25 aclk = ~aclk;

    scirq_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .user_card_present(user_card_present),
        .slot_overcurrent(slot_overcurrent), .main_supply_low(main_supply_low),
        .io_supply_low(io_supply_low), .over_temp(over_temp), .gpio_in(gpio_in),
        .atr_early(atr_early), .atr_late(atr_late), .ramp_timeout(ramp_timeout),
        .sync_act_done(sync_act_done), .seq_rst(seq_rst), .rst_limit(rst_limit),
        .card_rst(card_rst), .deactivate_all(deactivate_all), .power_off(power_off),
        .functions_ready(functions_ready), .irq_o(irq_o), .irq_oe(irq_oe));

    scirq_host u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rvalid(rvalid), .rready(rready));

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_reg(input string what, input int exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp[31:0]) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic chk_pin(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    function automatic int expect_rd(input logic [7:0] a);
        case (a)
            8'h04: return ev_m;
            8'h00: return st_m[0];
            8'h40: return st_m[1] | live_m;
            8'h80: return st_m[2];
            8'hc0: return st_m[3];
            8'h24: return sync_m;
            default: return 0;
        endcase
    endfunction

    // reads one register, compares with the model, then applies the read-clear
    task automatic rd_chk(input logic [7:0] a, input string what);
        logic [31:0] d;
        u_host.rd(a, d);
        chk_reg(what, expect_rd(a), d);
        chk_reg("rresp", 0, {30'h0, rresp});
        if (a == 8'h04) ev_m = 0;
        if (a[5:0] == 6'h00) st_m[a[7:6]] = 0;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        while (functions_ready !== 1'b1 && n < 200) begin
            @(negedge aclk);
            n++;
        end
        // the power-on request follows one cycle after readiness
        @(negedge aclk);
        chk_pin("functions_ready", 1'b1, functions_ready);
        chk_pin("irq_oe", 1'b1, irq_oe);
    endtask

    initial begin
        #(50 * 20000);
        n_mismatch++;
        stop_test();
    end

    initial begin
        {aresetn, user_card_present, main_supply_low, io_supply_low, over_temp} = '0;
        {sync_act_done, gpio_in, slot_overcurrent, atr_early, atr_late} = '0;
        {ramp_timeout, seq_rst, rst_limit, ev_m, live_m, sync_m, gq} = '0;
        st_m = '{0, 0, 0, 0};
        wait_cyc(6);
        aresetn <= 1'b1;
        wait_cyc(10);
        chk_pin("functions_ready", 1'b0, functions_ready);
        chk_pin("irq_oe", 1'b0, irq_oe);
        wait_ready();
        chk_pin("irq_o", 1'b0, irq_o);
        rd_chk(8'h04, "event after power-on");
        chk_pin("irq_oe", 1'b0, irq_oe);
        io_supply_low <= 1'b1;
        wait_cyc(8);
        chk_pin("power_off", 1'b1, power_off);
        chk_pin("deactivate all", 1'b1, &deactivate_all);
        chk_pin("functions_ready", 1'b0, functions_ready);
        io_supply_low <= 1'b0;
        wait_ready();
        rd_chk(8'h04, "event after power-off");
        chk_pin("irq_oe", 1'b0, irq_oe);
        for (int p = 1; p >= 0; p--) begin
            user_card_present <= p[0];
            wait_cyc(8);
            ev_m = 32'h80;
            st_m[0] = 32'h04;
            chk_pin("irq_oe", 1'b1, irq_oe);
            rd_chk(8'h04, "event");
            chk_pin("irq_oe", 1'b0, irq_oe);
            rd_chk(8'h00, "user status");
            rd_chk(8'h00, "user status again");
        end
        for (int k = 0; k < 4; k++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge aclk);
                case (k)
                    0: slot_overcurrent[s] <= 1'b1;
                    1: atr_early[s] <= 1'b1;
                    2: atr_late[s] <= 1'b1;
                    default: ramp_timeout[s] <= 1'b1;
                endcase
                @(posedge aclk);
                {atr_early, atr_late, ramp_timeout} <= '0;
                wait_cyc(8);
                ev_m = (s == 0) ? 32'h80 : (32'h08 << s);
                st_m[s] = 1 << kbit[k];
                chk_pin("irq_oe", 1'b1, irq_oe);
                u_host.service(ev, st);
                slot_overcurrent <= 4'h0;
                chk_reg("slot event", ev_m, ev);
                chk_reg("slot status", st_m[s], st[s]);
                {ev_m, st_m[s]} = '0;
                chk_pin("irq_oe", 1'b0, irq_oe);
                rd_chk(8'(s * 64), "slot status again");
            end
        end
        for (int j = 0; j < 2; j++) begin
            if (j == 0) main_supply_low <= 1'b1;
            else over_temp <= 1'b1;
            wait_cyc(8);
            ev_m = 4 << j;
            live_m = 2 << j;
            if (j == 0) chk_pin("deactivate all", 1'b1, &deactivate_all);
            rd_chk(8'h04, "event");
            rd_chk(8'h40, "slot1 live state");
            {main_supply_low, over_temp} <= '0;
            wait_cyc(8);
            live_m = 0;
            rd_chk(8'h40, "slot1 live state cleared");
        end
        sync_act_done <= 1'b1;
        @(posedge aclk);
        sync_act_done <= 1'b0;
        wait_cyc(4);
        ev_m = 32'h02;
        rd_chk(8'h04, "sync done event");
        rd_chk(8'h04, "sync done cleared");
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            gpio_in <= r[7:0];
            wait_cyc(8);
            if (r[7:0] != gq[7:0]) ev_m = 1;
            gq = r[7:0];
            rd_chk(8'h04, "pin change event");
        end
        for (int m = 0; m < 4; m++) begin
            if (m == 1) u_host.wr(8'h50, 32'h1);
            if (m >= 2) u_host.wr(8'h24, (m == 2) ? 32'h08 : 32'h00);
            if (m == 2) u_host.wr(8'h50, 32'h3);
            sync_m = (m == 2) ? 8 : 0;
            rd_chk(8'h24, "sync settings");
            for (int i = 0; i < 4; i++) begin
                r = $random(seed);
                seq_rst <= r[3:0];
                rst_limit <= r[7:4];
                wait_cyc(2);
                e = r[3:0];
                if (m >= 2) e = (e & 14) | (m == 2);
                chk_reg("card_rst", e, {28'h0, card_rst});
                chk_reg("deactivate_all", 0, {28'h0, deactivate_all});
            end
        end
        u_host.wr(8'h50, 32'h0);
        u_host.wr(8'h14, 32'hff);
        chk_reg("bresp", 0, {30'h0, bresp});
        rd_chk(8'h14, "unmapped");
        stop_test();
    end
endmodule
